// file: hw/tcps_pkg.sv
package tcps_pkg;
  localparam int TCPS_AW = 4;
  localparam int TCPS_DW = 8;
  localparam logic [TCPS_AW-1:0] TCPS_CONTROL_OFS = 4'h0;
  localparam logic [TCPS_AW-1:0] TCPS_STATUS_OFS = 4'h1;
  localparam logic [TCPS_DW-1:0] TCPS_CONTROL_RST = 8'h00;
  localparam int TCPS_RUN_BIT = 7;
  localparam int TCPS_PRE_HI = 6;
  localparam int TCPS_PRE_LO = 4;
  localparam int TCPS_POST_HI = 3;
  localparam int TCPS_POST_LO = 0;
  localparam int TCPS_PRE_W = 3;
  localparam int TCPS_POST_W = 4;
  localparam int TCPS_PRE_CNT_W = 7;
  typedef enum logic [1:0] {
    TCPS_IDLE = 2'b00,
    TCPS_RUN = 2'b01
  } tcps_state_t;
endpackage

// file: hw/tcps_postscaler.sv
`timescale 1ns/1ps
`default_nettype none
module tcps_postscaler
  import tcps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic match,
  input wire logic [tcps_pkg::TCPS_POST_W-1:0] ratio_sel,
  output logic event_pulse,
  output logic [tcps_pkg::TCPS_POST_W-1:0] count
);
  logic [TCPS_POST_W-1:0] cnt_q, cnt_d;
  logic ev_q, ev_d;

  always_comb begin
    cnt_d = cnt_q;
    ev_d = 1'b0;
    if (!run) begin
      cnt_d = '0; // R1
    end else if (match) begin
      // Compare with >= so a ratio lowered mid-count still ends promptly
      if (cnt_q >= ratio_sel) begin
        cnt_d = '0;
        ev_d = 1'b1; // R3 R6
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      ev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ev_q <= ev_d;
    end
  end

  assign event_pulse = ev_q;
  assign count = cnt_q;

  a_post_event: assert property (@(posedge ref_clk) disable iff (reset)
    (run && match && cnt_q >= ratio_sel) |=> (ev_q && cnt_q == 0))
    else $error("postscaler event missing"); // R3
  a_post_stop: assert property (@(posedge ref_clk) disable iff (reset)
    !run |=> (cnt_q == 0 && !ev_q))
    else $error("postscaler not held in reset"); // R1
endmodule
`default_nettype wire

// file: hw/tcps_top.sv
// Behaviour
// [R1] The run bit starts the timer; clearing it holds every counter idle.
// [R2] The prescaler divides the input clock tick by two to the field value.
// [R3] The postscaler ratio is the field value plus one.
// [R4] Run is bit 7, prescale bits 6-4, postscale bits 3-0, all read/write.
// [R5] Hardware may clear the run bit on its own, via an auto-stop request.
// [R6] Postscaler counts period matches; divider writes act next count cycle.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcps_top
  import tcps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [tcps_pkg::TCPS_AW-1:0] addr,
  input wire logic [tcps_pkg::TCPS_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [tcps_pkg::TCPS_DW-1:0] rdata,
  input wire logic tick_in,
  input wire logic period_match,
  input wire logic hw_stop,
  output logic run_out,
  output logic presc_tick,
  output logic post_event
);
  import tcps_pkg::*;

  function automatic logic [TCPS_PRE_CNT_W-1:0] pre_mask(
    input logic [TCPS_PRE_W-1:0] sel);
    pre_mask = TCPS_PRE_CNT_W'((8'h01 << sel) - 8'h01);
  endfunction

  logic [TCPS_DW-1:0] ctl_q, ctl_d;
  logic [TCPS_DW-1:0] rdata_q, rdata_d;
  tcps_state_t st_q, st_d;
  logic [TCPS_PRE_CNT_W-1:0] pre_q, pre_d;
  logic ptick_q, ptick_d;
  logic run;
  logic [TCPS_PRE_W-1:0] pre_sel;
  logic [TCPS_POST_W-1:0] post_sel;
  logic [TCPS_POST_W-1:0] post_cnt;

  assign run = ctl_q[TCPS_RUN_BIT]; // R4
  assign pre_sel = ctl_q[TCPS_PRE_HI:TCPS_PRE_LO]; // R4
  assign post_sel = ctl_q[TCPS_POST_HI:TCPS_POST_LO]; // R4

  // Register file; hardware stop wins over a software write of the run bit
  always_comb begin
    ctl_d = ctl_q;
    rdata_d = '0;
    if (wr && addr == TCPS_CONTROL_OFS) begin
      ctl_d = wdata; // R4
    end
    if (hw_stop) begin
      ctl_d[TCPS_RUN_BIT] = 1'b0; // R5
    end
    if (rd) begin
      if (addr == TCPS_CONTROL_OFS) begin
        rdata_d = ctl_q; // R4
      end else if (addr == TCPS_STATUS_OFS) begin
        rdata_d = {1'b0, pre_q};
      end else begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_q <= TCPS_CONTROL_RST;
      rdata_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  // Prescaler; a narrower select takes effect at once by masking the count
  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    ptick_d = 1'b0;
    case (st_q)
      TCPS_IDLE: begin
        pre_d = '0; // R1
        if (run) begin
          st_d = TCPS_RUN;
        end
      end
      TCPS_RUN: begin
        if (!run) begin
          st_d = TCPS_IDLE;
          pre_d = '0; // R1
        end else if (tick_in) begin
          if ((pre_q & pre_mask(pre_sel)) == pre_mask(pre_sel)) begin
            pre_d = '0;
            ptick_d = 1'b1; // R2 R6
          end else begin
            pre_d = pre_q + 1'b1;
          end
        end
      end
      default: begin
        st_d = TCPS_IDLE;
        pre_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q <= TCPS_IDLE;
      pre_q <= '0;
      ptick_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      ptick_q <= ptick_d;
    end
  end

  tcps_postscaler u_post (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(run),
    .match(period_match),
    .ratio_sel(post_sel),
    .event_pulse(post_event),
    .count(post_cnt)
  );

  assign rdata = rdata_q;
  assign run_out = ctl_q[TCPS_RUN_BIT];
  assign presc_tick = ptick_q;

  a_run_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !run |=> (pre_q == 0 && !ptick_q))
    else $error("prescaler active while stopped"); // R1
  a_pre_div1: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == TCPS_RUN && run && tick_in && pre_sel == 3'h0) |=> ptick_q)
    else $error("1:1 prescale missed a tick"); // R2
  a_pre_no_early: assert property (@(posedge ref_clk) disable iff (reset)
    (tick_in && run && st_q == TCPS_RUN && pre_sel == 3'h1 && pre_q == 0)
    |=> !ptick_q)
    else $error("1:2 prescale fired early"); // R2
  a_ctl_write: assert property (@(posedge ref_clk) disable iff (reset)
    (wr && addr == TCPS_CONTROL_OFS && !hw_stop) |=> ctl_q == $past(wdata))
    else $error("control write lost"); // R4
  a_ctl_read: assert property (@(posedge ref_clk) disable iff (reset)
    (rd && addr == TCPS_CONTROL_OFS) |=> rdata == $past(ctl_q))
    else $error("control read wrong"); // R4
  a_hw_clear: assert property (@(posedge ref_clk) disable iff (reset)
    hw_stop |=> !run_out)
    else $error("auto stop ignored"); // R5
  a_post_gate: assert property (@(posedge ref_clk) disable iff (reset)
    post_event |-> $past(period_match) && $past(run))
    else $error("event without match"); // R6
  a_post_range: assert property (@(posedge ref_clk) disable iff (reset)
    post_event |-> $past(post_cnt) >= $past(post_sel))
    else $error("event before ratio"); // R3

  // Bus side: read data stands one cycle only, stray accesses do nothing
  a_rd_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data outside read cycle"); // R4

  a_status_read: assert property (@(posedge ref_clk) disable iff (reset)
    (rd && addr == TCPS_STATUS_OFS) |=> rdata == {1'b0, $past(pre_q)})
    else $error("status read wrong"); // R4

  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (reset)
    (rd && addr != TCPS_CONTROL_OFS && addr != TCPS_STATUS_OFS)
    |=> rdata == 8'h00)
    else $error("unmapped read not zero"); // R4

  a_other_write: assert property (@(posedge ref_clk) disable iff (reset)
    (wr && addr != TCPS_CONTROL_OFS && !hw_stop) |=> ctl_q == $past(ctl_q))
    else $error("stray write changed control"); // R4

  a_ctl_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!wr && !hw_stop) |=> ctl_q == $past(ctl_q))
    else $error("control changed on its own"); // R4

  a_run_out_rise: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(run_out)
    |-> $past(wr && addr == TCPS_CONTROL_OFS && wdata[TCPS_RUN_BIT]))
    else $error("run set without a write"); // R4

  // Prescaler state follows the run bit
  a_run_enter: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == TCPS_IDLE && run) |=> st_q == TCPS_RUN)
    else $error("prescaler did not start"); // R1

  a_stop_enter: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == TCPS_RUN && !run) |=> st_q == TCPS_IDLE)
    else $error("prescaler did not stop"); // R1

  a_state_legal: assert property (@(posedge ref_clk) disable iff (reset)
    st_q == TCPS_IDLE || st_q == TCPS_RUN)
    else $error("prescaler state illegal"); // R1

  // Prescaler counting; the 1:128 end point is checked by value
  a_pre_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == TCPS_RUN && run && !tick_in)
    |=> (pre_q == $past(pre_q) && !ptick_q))
    else $error("prescaler moved without tick"); // R2

  a_pre_wrap: assert property (@(posedge ref_clk) disable iff (reset)
    ptick_q |-> pre_q == 7'h00)
    else $error("prescaler not cleared on tick"); // R2

  a_pre_div128: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == TCPS_RUN && run && tick_in && pre_sel == 3'h7 &&
    pre_q == 7'h7f) |=> ptick_q)
    else $error("1:128 prescale missed"); // R2

  a_tick_gate: assert property (@(posedge ref_clk) disable iff (reset)
    ptick_q |-> ($past(tick_in) && $past(run)))
    else $error("tick without input or run"); // R1

  // Postscaler output as seen at the top
  a_post_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    !period_match |=> !post_event)
    else $error("event without a match"); // R6

  a_post_div1: assert property (@(posedge ref_clk) disable iff (reset)
    (run && period_match && post_sel == 4'h0) |=> post_event)
    else $error("1:1 postscale missed"); // R3

  a_post_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !run |=> !post_event)
    else $error("event while stopped"); // R1
endmodule
`default_nettype wire

// file: dv/test_timer_control_prescale_postscale.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_control_prescale_postscale;
  import tcps_pkg::*;
  logic ref_clk = 0, reset = 1, wr = 0, rd = 0;
  logic tick_in = 0, period_match = 0, hw_stop = 0;
  logic [TCPS_AW-1:0] addr = '0;
  logic [TCPS_DW-1:0] wdata = '0, rdata, got;
  logic run_out, presc_tick, post_event;
  int num_errors = 0, samples_checked = 0, n;
  // Row: value written, value read back
  logic [7:0] rows [4][2] = '{'{8'h7f, 8'h7f}, '{8'hda, 8'hda},
    '{8'ha5, 8'ha5}, '{8'h00, 8'h00}};
  always #2.5 ref_clk = ~ref_clk;
  tcps_top dut_u (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tick_in(tick_in),
    .period_match(period_match), .hw_stop(hw_stop), .run_out(run_out),
    .presc_tick(presc_tick), .post_event(post_event));
  task chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge ref_clk);
    wr <= 0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a; rd <= 1;
    @(posedge ref_clk);
    rd <= 0;
    #1 got = rdata;
  endtask
  // Cycles between two pulses; bounded so a dead output cannot hang
  task period(input bit post);
    bit hit;
    n = 0;
    hit = 0;
    repeat (300) begin
      @(posedge ref_clk); #1;
      if (post ? post_event : presc_tick) begin
        hit = 1;
        break;
      end
    end
    if (!hit) num_errors++;
    hit = 0;
    repeat (300) begin
      @(posedge ref_clk); #1; n++;
      if (post ? post_event : presc_tick) begin
        hit = 1;
        break;
      end
    end
    if (!hit) num_errors++;
  endtask
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 0;
    #1 chk("run_out", {7'h0, run_out}, 8'h00);
    rd_reg(TCPS_CONTROL_OFS);
    chk("reset", got, TCPS_CONTROL_RST);
    $display("reset done");
    foreach (rows[i]) begin
      wr_reg(TCPS_CONTROL_OFS, rows[i][0]);
      rd_reg(TCPS_CONTROL_OFS);
      chk("readback", got, rows[i][1]);
    end
    rd_reg(4'h5);
    chk("unmapped", got, 8'h00);
    rd_reg(TCPS_STATUS_OFS);
    chk("status", got, 8'h00);
    wr_reg(TCPS_STATUS_OFS, 8'hff);
    rd_reg(TCPS_CONTROL_OFS);
    chk("status_wr", got, 8'h00);
    $display("rows done");
    tick_in <= 1;
    for (int s = 0; s < 8; s++) begin
      wr_reg(TCPS_CONTROL_OFS, 8'h80 | 8'(s << 4));
      period(0);
      chk("prescale", n[7:0], 8'(1 << s));
    end
    wr_reg(TCPS_CONTROL_OFS, 8'h00);
    n = 0;
    repeat (20) begin
      @(posedge ref_clk); #1;
      if (presc_tick !== 1'b0 || post_event !== 1'b0) n++;
    end
    chk("stopped", n[7:0], 8'h00);
    $display("prescale done");
    tick_in <= 0;
    period_match <= 1;
    for (int p = 0; p < 16; p += 5) begin
      wr_reg(TCPS_CONTROL_OFS, 8'h80 | 8'(p));
      period(1);
      chk("postscale", n[7:0], 8'(p + 1));
    end
    period_match <= 0;
    $display("postscale done");
    // Hardware clear must beat a software set in the same cycle
    hw_stop <= 1;
    wr_reg(TCPS_CONTROL_OFS, 8'h80);
    hw_stop <= 0;
    @(posedge ref_clk); #1;
    chk("hw_win", {7'h0, run_out}, 8'h00);
    wr_reg(TCPS_CONTROL_OFS, 8'h93);
    #1 chk("run_set", {7'h0, run_out}, 8'h01);
    @(posedge ref_clk);
    hw_stop <= 1;
    @(posedge ref_clk);
    hw_stop <= 0;
    rd_reg(TCPS_CONTROL_OFS);
    chk("hw_clear", got, 8'h13);
    $display("auto clear done");
    wr_reg(TCPS_CONTROL_OFS, 8'hc7);
    @(posedge ref_clk);
    reset <= 1;
    @(posedge ref_clk); #1;
    chk("rst_run", {7'h0, run_out}, 8'h00);
    @(posedge ref_clk);
    reset <= 0;
    rd_reg(TCPS_CONTROL_OFS);
    chk("rst_ctl", got, TCPS_CONTROL_RST);
    $display("mid reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
